//--- core/aaop_pkg.sv
package aaop_pkg;
  // ==========================================================
  // instruction word fields
  // ==========================================================
  localparam int unsigned INSN_W      = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned TARGET_POS  = 7;
  localparam int unsigned OPHI_POS    = 8;
  // top six bits of each opcode
  localparam logic [5:0]  OP_ADD_IMM  = 6'h3E; // 11 111x, low bit ignored
  localparam logic [5:0]  OP_AND_IMM  = 6'h39; // 11 1001
  localparam logic [5:0]  OP_ADD_REG  = 6'h07; // 00 0111
  localparam logic [5:0]  OP_AND_REG  = 6'h05; // 00 0101
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic        FLAG_RESET  = 1'h0;
  localparam int unsigned EXEC_CYCLES = 1;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef enum logic [2:0]
  {
    AAOP_NONE    = 3'b000,
    AAOP_ADD_IMM = 3'b001,
    AAOP_ADD_REG = 3'b010,
    AAOP_AND_IMM = 3'b011,
    AAOP_AND_REG = 3'b100
  } aaop_kind_t;

  typedef struct packed
  {
    logic carry;
    logic nibble_overflow_bit;
    logic zero;
  } aaop_flags_t;

  typedef struct packed
  {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } aaop_file_wr_t;
endpackage

//--- core/aaop_alu.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - add-immediate adds literal to accumulator, result to accumulator, sets carry, nibble carry, zero.
// - add-register adds accumulator and file register 0..127, sets carry, nibble carry, zero, one cycle.
// - target bit 0 stores to accumulator, bit 1 writes back to file register.
// - and-immediate ANDs literal with accumulator into accumulator, only zero changes, one cycle.
module aaop_alu
(
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          insn_valid,
  input  wire logic [aaop_pkg::INSN_W-1:0]   insn,
  input  wire logic [aaop_pkg::DATA_W-1:0]   file_rdata,
  output logic      [aaop_pkg::ADDR_W-1:0]   file_raddr,
  output var aaop_pkg::aaop_file_wr_t        file_wr,
  output logic      [aaop_pkg::DATA_W-1:0]   acc,
  output var aaop_pkg::aaop_flags_t          flags,
  output logic                               insn_hit
);

  // ==========================================================
  // decode
  // ==========================================================
  logic [5:0]                      op_top;
  aaop_pkg::aaop_kind_t            kind;
  logic [aaop_pkg::DATA_W-1:0]     literal;
  logic                            to_file;

  assign op_top     = insn[aaop_pkg::INSN_W-1:aaop_pkg::OPHI_POS];
  assign literal    = insn[aaop_pkg::DATA_W-1:0];
  assign to_file    = insn[aaop_pkg::TARGET_POS];
  assign file_raddr = insn[aaop_pkg::ADDR_W-1:0]; // operand read combinationally, same cycle

  // pick the instruction; unknown opcodes leave acc and flags alone, but an enabled edge still drops the write strobe
  always_comb
  begin
    kind = aaop_pkg::AAOP_NONE;
    if (insn_valid)
    begin
      if (op_top[5:1] == aaop_pkg::OP_ADD_IMM[5:1])
        kind = aaop_pkg::AAOP_ADD_IMM;
      else if (op_top == aaop_pkg::OP_AND_IMM)
        kind = aaop_pkg::AAOP_AND_IMM;
      else if (op_top == aaop_pkg::OP_ADD_REG)
        kind = aaop_pkg::AAOP_ADD_REG;
      else if (op_top == aaop_pkg::OP_AND_REG)
        kind = aaop_pkg::AAOP_AND_REG;
    end
  end
  assign insn_hit = (kind != aaop_pkg::AAOP_NONE);

  // ==========================================================
  // datapath
  // ==========================================================
  logic [aaop_pkg::DATA_W-1:0] operand;
  logic [aaop_pkg::DATA_W:0]   sum;
  logic [4:0]                  low_sum;
  logic [aaop_pkg::DATA_W-1:0] result;
  logic                        is_add;
  logic                        is_reg;

  assign is_add  = (kind == aaop_pkg::AAOP_ADD_IMM) || (kind == aaop_pkg::AAOP_ADD_REG);
  assign is_reg  = (kind == aaop_pkg::AAOP_ADD_REG) || (kind == aaop_pkg::AAOP_AND_REG);
  assign operand = is_reg ? file_rdata : literal;
  assign sum     = {1'h0, acc} + {1'h0, operand};
  assign low_sum = {1'h0, acc[3:0]} + {1'h0, operand[3:0]};
  assign result  = is_add ? sum[aaop_pkg::DATA_W-1:0] : (acc & operand);

  // ==========================================================
  // accumulator; only register forms may divert the result away
  // ==========================================================
  logic [aaop_pkg::DATA_W-1:0] acc_reg;
  aaop_pkg::aaop_file_wr_t     file_wr_reg;

  // a file-target op keeps the old value so the next op still sees it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      acc_reg <= aaop_pkg::ACC_RESET;
    else if (clk_en && insn_hit && !(is_reg && to_file))
      acc_reg <= result;
  end
  assign acc = acc_reg;

  // file write-back, registered so data comes from flip-flops
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      file_wr_reg <= '0;
    else if (clk_en)
    begin
      file_wr_reg.we   <= insn_hit && is_reg && to_file;
      file_wr_reg.addr <= file_raddr;
      file_wr_reg.data <= result;
    end
  end
  // strobe clears at the next enabled edge; address and data only count under it
  assign file_wr = file_wr_reg;

  // ==========================================================
  // status flags; logical ops leave carry and nibble carry alone
  // ==========================================================
  aaop_pkg::aaop_flags_t flags_reg;

  // zero follows the result even when it lands in the file register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= '{aaop_pkg::FLAG_RESET, aaop_pkg::FLAG_RESET, aaop_pkg::FLAG_RESET};
    else if (clk_en && insn_hit)
    begin
      flags_reg.zero <= (result == '0);
      if (is_add)
      begin
        flags_reg.carry               <= sum[aaop_pkg::DATA_W];
        flags_reg.nibble_overflow_bit <= low_sum[4];
      end
    end
  end
  assign flags = flags_reg;

  // ==========================================================
  // checks
  // ==========================================================
  // expected values are rebuilt from sampled inputs, not from the datapath nets, except that a_target_acc picks its operation from $past(is_add)
  property p_add_imm;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_ADD_IMM) |=>
      {flags.carry, acc} == ({1'h0, $past(acc)} + {1'h0, $past(literal)}) && flags.zero == (acc == 8'h00);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate result wrong");

  property p_add_reg_nib;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_ADD_REG) |=>
      flags.nibble_overflow_bit == ($past(acc[3:0]) + $past(file_rdata[3:0]) > 5'h0F);
  endproperty
  a_add_reg_nib: assert property (p_add_reg_nib) else $error("nibble carry wrong");

  property p_target_file;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && is_reg && to_file && insn_hit) |=> file_wr.we && $stable(acc);
  endproperty
  a_target_file: assert property (p_target_file) else $error("file target not honoured");

  property p_target_acc;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && is_reg && !to_file && insn_hit) |=>
      !file_wr.we && acc == ($past(is_add) ? 8'($past(acc) + $past(file_rdata)) : ($past(acc) & $past(file_rdata)));
  endproperty
  a_target_acc: assert property (p_target_acc) else $error("acc target not honoured");

  property p_and_imm;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_AND_IMM) |=>
      acc == ($past(acc) & $past(literal)) && $stable(flags.carry) && $stable(flags.nibble_overflow_bit);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

  property p_and_reg;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_AND_REG) |=>
      flags.zero == (($past(acc) & $past(file_rdata)) == 8'h00) && $stable(flags.carry);
  endproperty
  a_and_reg: assert property (p_and_reg) else $error("and register wrong");

  property p_freeze;
    @(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(acc) && $stable(flags) && $stable(file_wr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_wr_once;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && !insn_hit) |=> !file_wr.we;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("spurious file write");

  property p_add_imm_nib;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_ADD_IMM) |=>
      flags.nibble_overflow_bit == (({1'h0, $past(acc[3:0])} + {1'h0, $past(literal[3:0])}) > 5'h0F);
  endproperty
  a_add_imm_nib: assert property (p_add_imm_nib) else $error("add immediate nibble carry wrong");

  property p_add_reg_sum;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_ADD_REG) |=>
      flags.carry == (({1'h0, $past(acc)} + {1'h0, $past(file_rdata)}) > 9'h0FF);
  endproperty
  a_add_reg_sum: assert property (p_add_reg_sum) else $error("add register carry wrong");

  property p_add_file_data;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_ADD_REG && to_file) |=>
      file_wr.data == 8'($past(acc) + $past(file_rdata)) && file_wr.addr == $past(insn[aaop_pkg::ADDR_W-1:0]);
  endproperty
  a_add_file_data: assert property (p_add_file_data) else $error("add write-back wrong");

  property p_and_file_data;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_AND_REG && to_file) |=>
      file_wr.data == ($past(acc) & $past(file_rdata)) && file_wr.addr == $past(insn[aaop_pkg::ADDR_W-1:0]);
  endproperty
  a_and_file_data: assert property (p_and_file_data) else $error("and write-back wrong");

  property p_and_imm_zero;
    @(posedge clock) disable iff (!rst_n)
    (clk_en && kind == aaop_pkg::AAOP_AND_IMM) |=>
      flags.zero == (($past(acc) & $past(literal)) == 8'h00);
  endproperty
  a_and_imm_zero: assert property (p_and_imm_zero) else $error("and immediate zero flag wrong");

  property p_idle_hit;
    @(posedge clock) disable iff (!rst_n)
    !insn_valid |-> !insn_hit;
  endproperty
  a_idle_hit: assert property (p_idle_hit) else $error("hit without a valid instruction");

endmodule

`default_nettype wire

//--- tb/add_and_alu_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none

module add_and_alu_ops_tb;
  logic                    clock;
  logic                    rst_n;
  logic                    clk_en;
  logic                    insn_valid;
  logic [13:0]             insn;
  logic [7:0]              file_rdata;
  logic [6:0]              file_raddr;
  aaop_pkg::aaop_file_wr_t file_wr;
  logic [7:0]              acc;
  aaop_pkg::aaop_flags_t   flags;
  logic                    insn_hit;
  int                      error_cnt = 0;
  int                      check_count = 0;

  aaop_alu i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .insn_valid(insn_valid), .insn(insn),
    .file_rdata(file_rdata), .file_raddr(file_raddr), .file_wr(file_wr), .acc(acc), .flags(flags),
    .insn_hit(insn_hit));

  // ==========================================================
  // clock and watchdog
  // ==========================================================
  // 40 ns period
  initial
  begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // run needs about 31 cycles, so 500 means a hang
  initial
  begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one instruction, then valid drops so it is taken only once
  task automatic op(input logic [13:0] w, input logic [7:0] rd, input logic v, input logic en, input logic h);
    @(posedge clock);
    insn <= w;
    file_rdata <= rd;
    insn_valid <= v;
    clk_en <= en;
    #1;
    chk({file_raddr, insn_hit}, {w[6:0], h});
    @(posedge clock);
    insn_valid <= 1'h0;
    clk_en <= 1'h1;
    #1;
  endtask

  // write address and data only matter while the strobe is up
  task automatic res(input logic [7:0] a, input logic [2:0] f, input logic [15:0] w);
    chk({acc, flags, file_wr.we}, {a, f, w[15]});
    if (w[15])
      chk(file_wr, w);
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_add_imm();
    res(8'h00, 3'h0, 16'h0000);
    op({aaop_pkg::OP_ADD_IMM, 8'h10}, 8'h00, 1'h1, 1'h1, 1'h1);
    res(8'h10, 3'h0, 16'h0000);
    op({aaop_pkg::OP_ADD_IMM | 6'h01, 8'h15}, 8'h00, 1'h1, 1'h1, 1'h1);
    res(8'h25, 3'h0, 16'h0000);
    op({aaop_pkg::OP_ADD_IMM, 8'hDB}, 8'h00, 1'h1, 1'h1, 1'h1);
    res(8'h00, 3'h7, 16'h0000);
    $display("add immediate done");
  endtask

  task automatic t_add_reg();
    op({aaop_pkg::OP_ADD_IMM, 8'h17}, 8'h00, 1'h1, 1'h1, 1'h1);
    op({aaop_pkg::OP_ADD_REG, 1'h0, 7'h7F}, 8'hC2, 1'h1, 1'h1, 1'h1);
    res(8'hD9, 3'h0, 16'h0000);
    op({aaop_pkg::OP_ADD_REG, 1'h1, 7'h05}, 8'h01, 1'h1, 1'h1, 1'h1);
    res(8'hD9, 3'h0, 16'h85DA);
    op({aaop_pkg::OP_ADD_REG, 1'h1, 7'h00}, 8'h27, 1'h1, 1'h1, 1'h1);
    res(8'hD9, 3'h7, 16'h8000);
    $display("add register done");
  endtask

  // carry and nibble flags stay set across the logic ops
  task automatic t_and();
    op({aaop_pkg::OP_AND_IMM, 8'h5F}, 8'h00, 1'h1, 1'h1, 1'h1);
    res(8'h59, 3'h6, 16'h0000);
    op({aaop_pkg::OP_AND_REG, 1'h1, 7'h04}, 8'hC2, 1'h1, 1'h1, 1'h1);
    res(8'h59, 3'h6, 16'h8440);
    op({aaop_pkg::OP_AND_REG, 1'h1, 7'h15}, 8'h26, 1'h1, 1'h1, 1'h1);
    res(8'h59, 3'h7, 16'h9500);
    op({aaop_pkg::OP_AND_REG, 1'h0, 7'h2A}, 8'h0F, 1'h1, 1'h1, 1'h1);
    res(8'h09, 3'h6, 16'h0000);
    $display("and done");
  endtask

  task automatic t_refuse();
    op({6'h3A, 8'hFF}, 8'h00, 1'h1, 1'h1, 1'h0);
    res(8'h09, 3'h6, 16'h0000);
    op({aaop_pkg::OP_ADD_IMM, 8'h01}, 8'h00, 1'h0, 1'h1, 1'h0);
    res(8'h09, 3'h6, 16'h0000);
    op({aaop_pkg::OP_ADD_IMM, 8'h01}, 8'h00, 1'h1, 1'h0, 1'h1);
    res(8'h09, 3'h6, 16'h0000);
    $display("refusal done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reset for three cycles, then the scenarios in turn
  initial
  begin
    rst_n = 1'h0;
    clk_en = 1'h1;
    insn_valid = 1'h0;
    insn = 14'h0000;
    file_rdata = 8'h00;
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    t_add_imm();
    t_add_reg();
    t_and();
    t_refuse();
    tally_and_finish();
  end
endmodule

`default_nettype wire
